// File: rtl/scd_decoder.sv
// storage command decoder top: security-send fields and io opcode map
`timescale 1ns/10ps
`default_nettype none
module scd_decoder (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // configuration
  input wire logic ready_i,
  input wire logic rsv_support_i,
  input wire logic [scd_pkg::OPT_W-1:0] opt_en_i,
  input wire logic [255:0] proto_supported_i,
  input wire logic [scd_pkg::LBS_W-1:0] lbs_log2_i,
  // command request
  input wire logic cmd_valid_i,
  input wire logic cmd_admin_i,
  input wire logic [7:0] cmd_opcode_i,
  input wire logic [31:0] cmd_ns_id_i,
  input wire logic [127:0] cmd_buf_ptr_i,
  input wire logic [31:0] cmd_dw10_i,
  input wire logic [31:0] cmd_dw11_i,
  input wire logic [31:0] cmd_dw12_i,
  output logic cmd_ready_o,
  // decoded result
  output logic dec_valid_o,
  output logic dec_admin_cq_o,
  output logic [7:0] dec_status_o,
  output logic [1:0] dec_dir_o,
  output logic dec_xfer_o,
  output logic dec_limited_retry_o,
  output logic [31:0] dec_ns_id_o,
  output logic [127:0] dec_data_buffer_pointer_o,
  output logic [7:0] dec_security_protocol_id_o,
  output logic [15:0] dec_protocol_specific_o,
  output logic [7:0] dec_interface_security_subfield_o,
  output logic dec_replay_protected_block_o,
  output logic [31:0] dec_transfer_byte_length_o,
  output logic [31:0] dec_block_bytes_o,
  output logic sec_rsp_pending_o
);
  import scd_pkg::*;

  scd_if cif ();
  scd_state_t state_q;
  logic admin_q;
  logic [7:0] opc_q;
  logic [31:0] ns_id_q;
  logic [127:0] buf_ptr_q;
  logic [31:0] dw10_q;
  logic [31:0] dw11_q;
  logic retry_lim_q;
  logic take;
  logic is_sec;
  logic [7:0] proto_id;
  logic [15:0] spsp;
  logic [7:0] st_d;

  assign take = cmd_valid_i && (state_q == SCD_IDLE);
  assign is_sec = admin_q && (opc_q == OPC_SEC_SEND);
  assign cif.opcode = opc_q;
  assign cif.opt_en = opt_en_i;
  assign cif.rsv_en = rsv_support_i;
  // fields straight from dword 10
  assign proto_id = dw10_q[PROTO_ID_LSB +: 8];
  assign spsp = {dw10_q[SPSP_HI_LSB +: 8],
                 dw10_q[SPSP_LO_LSB +: 8]};

  scd_opc_class u_cls (
    .c(cif.cls)
  );

  // one command in flight; host must hold request until taken
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_q <= SCD_IDLE;
    end else begin
      case (state_q)
        SCD_IDLE: if (cmd_valid_i) state_q <= SCD_DEC;
        SCD_DEC: state_q <= SCD_DONE;
        SCD_DONE: state_q <= SCD_IDLE;
        default: state_q <= SCD_IDLE;
      endcase
    end
  end

  // capture only the fields this set uses; other dwords ignored
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      admin_q <= 1'b0;
      opc_q <= 8'h00;
      ns_id_q <= 32'h0;
      buf_ptr_q <= 128'h0;
      dw10_q <= 32'h0;
      dw11_q <= 32'h0;
      retry_lim_q <= 1'b0;
    end else if (take) begin
      admin_q <= cmd_admin_i;
      opc_q <= cmd_opcode_i;
      ns_id_q <= cmd_ns_id_i;
      buf_ptr_q <= cmd_buf_ptr_i;
      dw10_q <= cmd_dw10_i;
      dw11_q <= cmd_dw11_i;
      retry_lim_q <= cmd_dw12_i[RETRY_LIM_BIT];
    end
  end

  // status priority: io not ready, bad opcode, ok; security send bad parameter, bad field, ok; other admin bad opcode
  always_comb begin
    st_d = ST_OK;
    if (is_sec) begin
      if (!proto_supported_i[proto_id]) begin
        st_d = ST_BAD_PARAM;
      end else if (proto_id == PROTO_IFACE && spsp != SPSP_RPB) begin
        st_d = ST_BAD_FIELD;
      end
    end else if (admin_q) begin
      st_d = ST_BAD_OPC;
    end else if (!ready_i) begin
      st_d = ST_NOT_READY;
    end else if (!cif.known || !cif.supported) begin
      st_d = ST_BAD_OPC;
    end
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cmd_ready_o <= 1'b0;
    end else begin
      cmd_ready_o <= (state_q == SCD_IDLE) && !cmd_valid_i;
    end
  end

  // result registers, one pulse of dec_valid_o per command
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      dec_valid_o <= 1'b0;
      dec_admin_cq_o <= 1'b0;
      dec_status_o <= ST_OK;
      dec_dir_o <= DIR_NONE;
      dec_xfer_o <= 1'b0;
      dec_limited_retry_o <= 1'b0;
      dec_ns_id_o <= 32'h0;
      dec_data_buffer_pointer_o <= 128'h0;
      dec_security_protocol_id_o <= 8'h00;
      dec_protocol_specific_o <= 16'h0000;
      dec_interface_security_subfield_o <= 8'h00;
      dec_replay_protected_block_o <= 1'b0;
      dec_transfer_byte_length_o <= 32'h0;
    end else if (state_q == SCD_DEC) begin
      dec_valid_o <= 1'b1;
      dec_admin_cq_o <= admin_q;
      dec_status_o <= st_d;
      dec_dir_o <= is_sec ? DIR_H2C : (admin_q ? DIR_NONE : cif.dir);
      dec_xfer_o <=
        (st_d == ST_OK) && (is_sec || cif.dir != DIR_NONE);
      dec_limited_retry_o <=
        !admin_q && cif.retry_ok && retry_lim_q;
      dec_ns_id_o <= ns_id_q;
      dec_data_buffer_pointer_o <= buf_ptr_q;
      dec_security_protocol_id_o <= is_sec ? proto_id : 8'h00;
      dec_protocol_specific_o <= is_sec ? spsp : 16'h0000;
      // subfield reserved unless protocol eah
      dec_interface_security_subfield_o <=
        (is_sec && proto_id == PROTO_IFACE) ? dw10_q[SUBF_LSB +: 8] : 8'h00;
      dec_replay_protected_block_o <=
        is_sec && proto_id == PROTO_IFACE && spsp == SPSP_RPB;
      dec_transfer_byte_length_o <= is_sec ? dw11_q : 32'h0;
    end else begin
      dec_valid_o <= 1'b0;
    end
  end

  // result waits for a security-receive; set wins over clear
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sec_rsp_pending_o <= 1'b0;
    end else if (state_q == SCD_DEC && is_sec && st_d == ST_OK) begin
      sec_rsp_pending_o <= 1'b1;
    end else if (state_q == SCD_DEC && admin_q && opc_q == OPC_SEC_RECV) begin
      sec_rsp_pending_o <= 1'b0;
    end
  end

  // shift keeps block size a power of two by construction
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      dec_block_bytes_o <= 32'h1 << LBS_RST;
    end else begin
      dec_block_bytes_o <= 32'h1 << lbs_log2_i;
    end
  end
endmodule // scd_decoder
`default_nettype wire

// File: rtl/scd_pkg.sv
// constants and types shared by the storage command decoder
package scd_pkg;
  localparam int DW_W = 32;
  localparam int OPC_W = 8;
  // opcodes of the io set
  localparam logic [7:0] OPC_FLUSH = 8'h00;
  localparam logic [7:0] OPC_WRITE = 8'h01;
  localparam logic [7:0] OPC_READ = 8'h02;
  localparam logic [7:0] OPC_WR_UNC = 8'h04;
  localparam logic [7:0] OPC_COMPARE = 8'h05;
  localparam logic [7:0] OPC_WR_ZERO = 8'h08;
  localparam logic [7:0] OPC_DSM = 8'h09;
  localparam logic [7:0] OPC_RSV_REG = 8'h0d;
  localparam logic [7:0] OPC_RSV_RPT = 8'h0e;
  localparam logic [7:0] OPC_RSV_ACQ = 8'h11;
  localparam logic [7:0] OPC_RSV_REL = 8'h15;
  localparam int OPC_VENDOR_BIT = 7;
  // admin opcodes of security send and receive
  localparam logic [7:0] OPC_SEC_SEND = 8'h81;
  localparam logic [7:0] OPC_SEC_RECV = 8'h82;
  // optional-feature enable bit positions
  localparam int OPT_WR_UNC = 0;
  localparam int OPT_COMPARE = 1;
  localparam int OPT_WR_ZERO = 2;
  localparam int OPT_DSM = 3;
  localparam int OPT_VENDOR = 4;
  localparam int OPT_W = 5;
  // dword 10 field positions
  localparam int PROTO_ID_LSB = 24;
  localparam int SPSP_HI_LSB = 16;
  localparam int SPSP_LO_LSB = 8;
  localparam int SUBF_LSB = 0;
  localparam logic [7:0] PROTO_IFACE = 8'hea;
  localparam logic [15:0] SPSP_RPB = 16'h0001;
  // limited retry is bit 31 of dword 12
  localparam int RETRY_LIM_BIT = 31;
  // direction codes
  localparam logic [1:0] DIR_NONE = 2'h0;
  localparam logic [1:0] DIR_H2C = 2'h1;
  localparam logic [1:0] DIR_C2H = 2'h2;
  localparam logic [1:0] DIR_BIDI = 2'h3;
  // status codes
  localparam logic [7:0] ST_OK = 8'h00;
  localparam logic [7:0] ST_BAD_OPC = 8'h01;
  localparam logic [7:0] ST_BAD_FIELD = 8'h02;
  localparam logic [7:0] ST_BAD_PARAM = 8'h1f;
  localparam logic [7:0] ST_NOT_READY = 8'h07;
  localparam int LBS_W = 4;
  localparam logic [3:0] LBS_RST = 4'h9;
  typedef enum logic [2:0] {
    SCD_IDLE = 3'b001,
    SCD_DEC = 3'b010,
    SCD_DONE = 3'b100
  } scd_state_t;
endpackage : scd_pkg

// File: rtl/scd_if.sv
// carrier between the top and the opcode classifier
`timescale 1ns/10ps
`default_nettype none
interface scd_if;
  logic [7:0] opcode;
  logic [scd_pkg::OPT_W-1:0] opt_en;
  logic rsv_en;
  logic known;
  logic supported;
  logic retry_ok;
  logic [1:0] dir;
  modport cls (input opcode, opt_en, rsv_en,
               output known, supported, retry_ok, dir);
  modport top (output opcode, opt_en, rsv_en,
               input known, supported, retry_ok, dir);
endinterface : scd_if
`default_nettype wire

// File: rtl/scd_opc_class.sv
// combinational opcode classifier for the io command set
`timescale 1ns/10ps
`default_nettype none
module scd_opc_class (
  // link to top
  scd_if.cls c
);
  import scd_pkg::*;
  always_comb begin
    c.dir = c.opcode[1:0];
    c.known = 1'b0;
    c.supported = 1'b0;
    c.retry_ok = 1'b0;
    if (c.opcode[OPC_VENDOR_BIT]) begin
      c.known = 1'b1;
      c.supported = c.opt_en[OPT_VENDOR];
    end else if (c.opcode == OPC_FLUSH || c.opcode == OPC_WRITE ||
                 c.opcode == OPC_READ) begin
      c.known = 1'b1;
      c.supported = 1'b1;
      c.retry_ok = (c.opcode != OPC_FLUSH);
    end else if (c.opcode == OPC_WR_UNC) begin
      c.known = 1'b1;
      c.supported = c.opt_en[OPT_WR_UNC];
    end else if (c.opcode == OPC_COMPARE) begin
      c.known = 1'b1;
      c.supported = c.opt_en[OPT_COMPARE];
      c.retry_ok = 1'b1;
    end else if (c.opcode == OPC_WR_ZERO) begin
      c.known = 1'b1;
      c.supported = c.opt_en[OPT_WR_ZERO];
      c.retry_ok = 1'b1;
    end else if (c.opcode == OPC_DSM) begin
      c.known = 1'b1;
      c.supported = c.opt_en[OPT_DSM];
    end else if (c.opcode == OPC_RSV_REG || c.opcode == OPC_RSV_RPT ||
                 c.opcode == OPC_RSV_ACQ || c.opcode == OPC_RSV_REL) begin
      c.known = 1'b1;
      c.supported = c.rsv_en;
    end
  end
endmodule // scd_opc_class
`default_nettype wire

// File: verification/scd_host_model.sv
// host model posting submission entries to the decoder
`timescale 1ns/10ps
`default_nettype none
module scd_host_model (
  // clock and answer
  input wire logic clk_sys_i,
  input wire logic cmd_ready_o,
  input wire logic dec_valid_o,
  // submission entry
  output logic cmd_valid_i,
  output logic cmd_admin_i,
  output logic [7:0] cmd_opcode_i,
  output logic [31:0] cmd_ns_id_i,
  output logic [127:0] cmd_buf_ptr_i,
  output logic [31:0] cmd_dw10_i,
  output logic [31:0] cmd_dw11_i,
  output logic [31:0] cmd_dw12_i
);
  initial begin
    {cmd_valid_i, cmd_admin_i, cmd_opcode_i, cmd_ns_id_i} = '0;
    {cmd_buf_ptr_i, cmd_dw10_i, cmd_dw11_i, cmd_dw12_i} = '0;
  end
  // one entry, raised once ready is seen or after 20 cycles without it, then wait for its answer
  task automatic snd(input logic a, input logic [7:0] o,
      input logic [31:0] n, d10, d11, d12, output logic tmo);
    int i;
    logic seen;
    tmo = 1'b1;
    for (i = 0; i < 20 && cmd_ready_o !== 1'b1; i++)
      @(posedge clk_sys_i);
    // a ready that never rises counts as a timeout
    seen = (cmd_ready_o === 1'b1);
    @(posedge clk_sys_i);
    cmd_valid_i <= 1'b1;
    cmd_admin_i <= a;
    cmd_opcode_i <= o;
    cmd_ns_id_i <= n;
    cmd_buf_ptr_i <= {d10, d11, d12, n};
    {cmd_dw10_i, cmd_dw11_i, cmd_dw12_i} <= {d10, d11, d12};
    @(posedge clk_sys_i);
    cmd_valid_i <= 1'b0;
    // released fields flip so a late capture shows
    {cmd_opcode_i, cmd_ns_id_i, cmd_buf_ptr_i} <= ~{o, n, d10, d11, d12, n};
    {cmd_dw10_i, cmd_dw11_i, cmd_dw12_i} <= ~{d10, d11, d12};
    for (i = 0; i < 8 && tmo; i++) begin
      @(posedge clk_sys_i);
      if (dec_valid_o === 1'b1)
        tmo = 1'b0;
    end
    if (!seen)
      tmo = 1'b1;
  endtask
endmodule // scd_host_model
`default_nettype wire

// File: verification/scd_decoder_chk.sv
// assertions on the ports of the storage command decoder
`timescale 1ns/10ps
`default_nettype none
module scd_decoder_chk
  import scd_pkg::*;
(
  // inputs
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic cmd_valid_i,
  input wire logic cmd_admin_i,
  input wire logic [7:0] cmd_opcode_i,
  input wire logic [31:0] cmd_dw10_i,
  input wire logic [31:0] cmd_dw11_i,
  // outputs
  input wire logic cmd_ready_o,
  input wire logic dec_valid_o,
  input wire logic [7:0] dec_status_o,
  input wire logic [1:0] dec_dir_o,
  input wire logic dec_xfer_o,
  input wire logic [15:0] dec_protocol_specific_o,
  input wire logic [7:0] dec_interface_security_subfield_o,
  input wire logic [7:0] dec_security_protocol_id_o,
  input wire logic [31:0] dec_transfer_byte_length_o,
  input wire logic [31:0] dec_block_bytes_o
);
  default clocking dc @(posedge clk_sys_i);
  endclocking
  default disable iff (sys_rst_i);
  logic tk;
  logic ss;
  // ready high means idle, so a raised request is taken
  assign tk = cmd_valid_i & cmd_ready_o;
  assign ss = tk & cmd_admin_i & (cmd_opcode_i == OPC_SEC_SEND);
  AST_LAT: assert property (tk |-> ##2 dec_valid_o)
    else $error("answer late");
  AST_ONE: assert property (dec_valid_o |=> !dec_valid_o)
    else $error("answer pulse long");
  AST_XFER: assert property (dec_valid_o |-> dec_xfer_o ==
    (dec_status_o == ST_OK && dec_dir_o != DIR_NONE)) else $error("xfer");
  AST_DIR: assert property (tk |-> ##2 (dec_status_o != ST_OK ||
    dec_dir_o == $past(cmd_opcode_i[1:0], 2))) else $error("direction");
  AST_SPSP: assert property (ss |-> ##2
    dec_protocol_specific_o == $past(cmd_dw10_i[23:8], 2)) else $error("spsp");
  AST_LEN: assert property (ss |-> ##2
    dec_transfer_byte_length_o == $past(cmd_dw11_i, 2)) else $error("len");
  AST_SUBF: assert property (dec_valid_o &&
    dec_security_protocol_id_o != PROTO_IFACE
    |-> dec_interface_security_subfield_o == 8'h00) else $error("subfield");
  AST_BLK: assert property ($onehot(dec_block_bytes_o))
    else $error("block size");
  cover property (ss ##2 dec_status_o == ST_OK);
  cover property (dec_valid_o && dec_status_o == ST_BAD_OPC);
  cover property (dec_valid_o && dec_dir_o == DIR_BIDI);
endmodule // scd_decoder_chk
bind scd_decoder scd_decoder_chk u_scd_decoder_chk (.*);
`default_nettype wire

// File: verification/scd_decoder_bench.sv
// self-checking bench for the storage command decoder
`timescale 1ns/10ps
`default_nettype none
module scd_decoder_bench;
  import scd_pkg::*;
  logic clk_sys_i, sys_rst_i, ready_i, rsv_support_i, tmo;
  logic [OPT_W-1:0] opt_en_i;
  logic [255:0] proto_supported_i;
  logic [LBS_W-1:0] lbs_log2_i;
  logic cmd_valid_i, cmd_admin_i, cmd_ready_o, dec_valid_o, dec_admin_cq_o;
  logic [7:0] cmd_opcode_i, dec_status_o, dec_security_protocol_id_o;
  logic [7:0] dec_interface_security_subfield_o;
  logic [31:0] cmd_ns_id_i, cmd_dw10_i, cmd_dw11_i, cmd_dw12_i, dec_ns_id_o;
  logic [31:0] dec_transfer_byte_length_o, dec_block_bytes_o;
  logic [127:0] cmd_buf_ptr_i, dec_data_buffer_pointer_o;
  logic [15:0] dec_protocol_specific_o;
  logic [1:0] dec_dir_o;
  logic dec_xfer_o, dec_limited_retry_o, dec_replay_protected_block_o;
  logic sec_rsp_pending_o;
  logic [7:0] opt_op[4] = '{OPC_WR_UNC, OPC_COMPARE, OPC_WR_ZERO, OPC_DSM};
  logic [7:0] rsv_op[4] =
    '{OPC_RSV_REG, OPC_RSV_RPT, OPC_RSV_ACQ, OPC_RSV_REL};
  int n_errors = 0;
  int tests_run = 0;
  scd_decoder u_scd_decoder (.*);
  scd_host_model u_scd_host_model (.*);
  initial begin
    clk_sys_i = 1'b0;
    forever #20 clk_sys_i = ~clk_sys_i;
  end
  task automatic close_out;
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic ok, input string m);
    tests_run++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask
  // namespace id is derived from the opcode so answers to different opcodes differ
  task automatic go(input logic a, input logic [7:0] o,
      input logic [31:0] d10, d11, d12);
    u_scd_host_model.snd(a, o, 32'h0a5c ^ {24'h0, o}, d10, d11, d12, tmo);
    if (tmo === 1'b1) begin
      n_errors++;
      close_out();
    end
  endtask
  task automatic io(input logic [7:0] o, input logic [7:0] st);
    go(1'b0, o, 32'h0, 32'h0, 32'h0);
    chk(dec_status_o === st, "io status");
    chk(dec_xfer_o === (st == ST_OK && o[1:0] != 2'h0), "xfer");
    chk(st != ST_OK || dec_dir_o === o[1:0], "dir");
    chk(dec_ns_id_o === (32'h0a5c ^ {24'h0, o}), "namespace");
  endtask
  task automatic t_map;
    int k;
    io(OPC_FLUSH, ST_OK);
    io(OPC_WRITE, ST_OK);
    io(OPC_READ, ST_OK);
    io(8'h03, ST_BAD_OPC);
    io(rsv_op[0], ST_BAD_OPC);
    for (k = 0; k < 4; k++) begin
      opt_en_i <= 5'h00;
      io(opt_op[k], ST_BAD_OPC);
      opt_en_i <= 5'h01 << k;
      io(opt_op[k], ST_OK);
      rsv_support_i <= 1'b1;
      io(rsv_op[k], ST_OK);
    end
    opt_en_i <= 5'h10;
    io(8'h83, ST_OK);
    io(8'hfe, ST_OK);
    opt_en_i <= 5'h00;
    io(8'h83, ST_BAD_OPC);
  endtask
  task automatic t_lr;
    go(1'b0, OPC_READ, 32'h0, 32'h0, 32'h8000_0000);
    chk(dec_limited_retry_o === 1'b1, "retry limit");
    go(1'b0, OPC_WRITE, 32'h0, 32'h0, 32'h7fff_ffff);
    chk(dec_limited_retry_o === 1'b0, "retry free");
    ready_i <= 1'b0;
    io(OPC_READ, ST_NOT_READY);
    ready_i <= 1'b1;
  endtask
  task automatic t_sec;
    go(1'b1, OPC_SEC_SEND, 32'hea00_0107, 32'h0000_0203, 32'h8000_0000);
    chk(dec_status_o === ST_OK, "sec ok");
    chk(dec_security_protocol_id_o === 8'hea, "protocol id");
    chk(dec_protocol_specific_o === 16'h0001, "spsp");
    chk(dec_replay_protected_block_o === 1'b1, "rpb");
    chk(dec_interface_security_subfield_o === 8'h07, "subf");
    chk(dec_transfer_byte_length_o === 32'h203, "len");
    chk(dec_limited_retry_o === 1'b0, "dword 12 ignored");
    chk(dec_data_buffer_pointer_o === {32'hea000107, 32'h203,
      32'h8000_0000, 32'h0add}, "ptr");
    chk(dec_admin_cq_o === 1'b1 && dec_xfer_o === 1'b1, "cq");
    go(1'b1, OPC_SEC_SEND, 32'h0212_3400, 32'h10, 32'h0);
    chk(dec_status_o === ST_BAD_PARAM, "reserved id");
    chk(sec_rsp_pending_o === 1'b1, "pending");
    go(1'b1, OPC_SEC_SEND, 32'hea00_0207, 32'h0, 32'h0);
    chk(dec_status_o === ST_BAD_FIELD, "usage");
    chk(dec_replay_protected_block_o === 1'b0, "no rpb");
    go(1'b1, OPC_SEC_SEND, 32'h01ab_cd55, 32'h0, 32'h0);
    chk(dec_protocol_specific_o === 16'habcd, "spsp");
    chk(dec_interface_security_subfield_o === 8'h00, "subf");
    go(1'b1, OPC_SEC_RECV, 32'h0, 32'h0, 32'h0);
    go(1'b1, 8'h06, 32'h0, 32'h0, 32'h0);
    chk(dec_status_o === ST_BAD_OPC, "admin opc");
    chk(sec_rsp_pending_o === 1'b0, "fetched");
  endtask
  task automatic t_lbs;
    chk(dec_block_bytes_o === 32'h200, "reset size");
    lbs_log2_i <= 4'hc;
    repeat (2) @(posedge clk_sys_i);
    chk(dec_block_bytes_o === 32'h1000, "size");
  endtask
  initial begin
    sys_rst_i = 1'b1;
    {ready_i, rsv_support_i, opt_en_i} = {1'b1, 1'b0, 5'h00};
    lbs_log2_i = 4'h9;
    proto_supported_i = 256'h2;
    proto_supported_i[8'hea] = 1'b1;
    repeat (10) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    t_lbs();
    t_map();
    t_lr();
    t_sec();
    close_out();
  end
endmodule // scd_decoder_bench
`default_nettype wire
